// ---- rtl/swbst_ctrl.sv ----
// swbst_ctrl: decode of the soft reset/keepalive, boost control and slew registers.
// assumes a host driving the 3-wire serial port and a watchdog enable level
// from clk_i-domain logic elsewhere in the part.
//
// Operation
// - top bits 100 select soft reset register
// - code 0x555 resets the whole part
// - toggle bit copied into status bit 11
// - missed service with watchdog on raises alert
// - watchdog off: no service needed, no alert
// - top bits 011 select boost control; D12-D7 ignored
// - bit 6 picks internal or external compensation
// - phase field sets per-channel clock edges
// - rate field divides 13 MHz oscillator
// - limit field caps boost output voltage
// - slew settings held per addressed channel
// - read flag set makes a readback request
`default_nettype none

module swbst_ctrl
    import swbst_pkg::*;
#(
    parameter int WDOG_TIMEOUT_CYCLES = WDOG_TIMEOUT_US * CLK_MHZ  // watchdog period
)
(
    input  wire logic                      clk_i,
    input  wire logic                      reset_i,
    input  wire logic                      ce_i,
    input  wire logic                      sclk_i,
    input  wire logic                      sync_n_i,
    input  wire logic                      serial_in_line_i,
    input  wire logic                      watchdog_enable_i,
    output logic                           sdo_o,
    output logic                           alert_o,
    output logic                           soft_reset_o,
    output logic                           user_toggle_o,
    output swbst_boost_s                   boost_cfg_o,
    output logic [5:0]                     boost_div_o,
    output logic [NUM_CH-1:0][1:0]         boost_phase_o,
    output swbst_slew_s [NUM_CH-1:0]       slew_cfg_o
);
    localparam int WD_W = $clog2(WDOG_TIMEOUT_CYCLES + 1);     // watchdog count width
    localparam logic [WD_W-1:0] WD_LAST = WD_W'(WDOG_TIMEOUT_CYCLES);

    swbst_frame_s          frame;                    // completed frame from receiver
    logic                  wr, rd;                   // write or readback frame
    logic [2:0]            sel;                      // register select field
    logic [11:0]           code;                     // soft register key
    logic                  soft_wr, boost_wr, slew_wr;
    logic                  do_reset, service;
    logic [1:0]            slew_ch;                  // channel of a slew write
    logic [4:0]            rd_addr;                  // readback address

    logic                  toggle_reg, toggle_next;  // status mirror bit
    logic                  srst_reg,   srst_next;    // soft reset pulse
    swbst_boost_s          boost_reg,  boost_next;
    logic [5:0]            div_reg,    div_next;
    logic [WD_W-1:0]       wd_cnt_reg, wd_cnt_next;  // cycles since last service
    logic                  alert_reg,  alert_next;
    logic                  load_reg,   load_next;    // readback word ready
    logic [FRAME_BITS-1:0] rdw_reg,    rdw_next;     // word to shift out next frame

    // serial receiver and readback shifter
    swbst_serial_rx u_rx (
        .clk_i            (clk_i),
        .reset_i          (reset_i),
        .ce_i             (ce_i),
        .sclk_i           (sclk_i),
        .sync_n_i         (sync_n_i),
        .serial_in_line_i (serial_in_line_i),
        .sdo_load_i       (load_reg),
        .sdo_word_i       (rdw_reg),
        .frame_o          (frame),
        .sdo_o            (sdo_o)
    );

    // frame classification
    always_comb
    begin
        rd       = frame.valid & frame.word[RW_BIT];
        wr       = frame.valid & ~frame.word[RW_BIT];
        sel      = frame.word[SEL_LO +: 3];
        code     = frame.word[11:0];
        soft_wr  = wr && sel == SEL_SOFT;
        boost_wr = wr && sel == SEL_BOOST;
        slew_wr  = wr && sel == SEL_SLEW;
        do_reset = soft_wr && code == CODE_RESET;
        service  = soft_wr && code == CODE_SERVICE;
        slew_ch  = frame.word[CH_LO +: 2];
        rd_addr  = frame.word[RD_LO +: 5];
    end

    // soft register, boost control and watchdog next values
    always_comb
    begin
        toggle_next = toggle_reg;
        boost_next  = boost_reg;
        srst_next   = do_reset;
        if (do_reset)
        begin
            // toggle bit and boost control back to their defaults
            toggle_next = 1'b0;
            boost_next  = '{comp: COMP_DEF, phase: PHASE_DEF,
                            rate: RATE_DEF, limit: LIMIT_DEF};
        end
        else if (soft_wr)
        begin
            toggle_next = frame.word[TOGGLE_BIT];
        end
        else if (boost_wr)
        begin
            // D12 to D7 are don't care
            boost_next.comp  = frame.word[COMP_BIT];
            boost_next.phase = frame.word[PHASE_LO +: 2];
            boost_next.rate  = frame.word[RATE_LO +: 2];
            boost_next.limit = frame.word[LIMIT_LO +: 2];
        end
        // divider from the oscillator, reserved code keeps the default rate
        case (boost_next.rate)
            2'h0:    div_next = DIV0;
            2'h1:    div_next = DIV1;
            2'h2:    div_next = DIV2;
            default: div_next = DIV1;
        endcase
        // watchdog: idle while disabled, restarted by service or reset
        if (!watchdog_enable_i || service || do_reset)
            wd_cnt_next = '0;
        else if (wd_cnt_reg != WD_LAST)
            wd_cnt_next = wd_cnt_reg + 1'b1;
        else
            wd_cnt_next = wd_cnt_reg;
        alert_next = watchdog_enable_i && wd_cnt_next == WD_LAST;
    end

    // readback word for the following frame
    always_comb
    begin
        load_next = frame.valid;
        rdw_next  = '0;
        if (rd)
        begin
            if (rd_addr == RD_STATUS)
            begin
                rdw_next[STAT_TOG_BIT] = toggle_reg;
            end
            else if (rd_addr == RD_BOOST)
            begin
                rdw_next[COMP_BIT]        = boost_reg.comp;
                rdw_next[PHASE_LO +: 2]   = boost_reg.phase;
                rdw_next[RATE_LO +: 2]    = boost_reg.rate;
                rdw_next[LIMIT_LO +: 2]   = boost_reg.limit;
            end
            else if (rd_addr[4:2] == RD_SLEW_GRP)
            begin
                rdw_next[SREN_BIT]        = slew_cfg_o[rd_addr[1:0]].enable;
                rdw_next[SRCLK_LO +: 4]   = slew_cfg_o[rd_addr[1:0]].clock;
                rdw_next[SRSTEP_LO +: 3]  = slew_cfg_o[rd_addr[1:0]].step;
            end
        end
    end

    // control registers
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            toggle_reg <= 1'b0;
            srst_reg   <= 1'b0;
            boost_reg  <= '{comp: COMP_DEF, phase: PHASE_DEF,
                           rate: RATE_DEF, limit: LIMIT_DEF};
            div_reg    <= DIV1;
            wd_cnt_reg <= '0;
            alert_reg  <= 1'b0;
            load_reg   <= 1'b0;
            rdw_reg    <= '0;
        end
        else if (ce_i)
        begin
            toggle_reg <= toggle_next;
            srst_reg   <= srst_next;
            boost_reg  <= boost_next;
            div_reg    <= div_next;
            wd_cnt_reg <= wd_cnt_next;
            alert_reg  <= alert_next;
            load_reg   <= load_next;
            rdw_reg    <= rdw_next;
        end
    end

    // per-channel phase offsets and slew settings
    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++)
        begin : g_ch
            logic [1:0]  ph_reg, ph_next;   // quarter-period offset of this channel
            swbst_slew_s sl_reg, sl_next;   // slew settings of this channel

            always_comb
            begin
                case (boost_next.phase)
                    2'h0:    ph_next = PH_SAME;
                    2'h1:    ph_next = (ch >= 2) ? PH_OPP : PH_SAME;
                    2'h2:    ph_next = (ch % 2 == 1) ? PH_OPP : PH_SAME;
                    default: ph_next = 2'(ch);
                endcase
                sl_next = sl_reg;
                if (do_reset)
                    sl_next = '0;
                else if (slew_wr && slew_ch == 2'(ch))
                begin
                    sl_next.enable = frame.word[SREN_BIT];
                    sl_next.clock  = frame.word[SRCLK_LO +: 4];
                    sl_next.step   = frame.word[SRSTEP_LO +: 3];
                end
            end

            always_ff @(posedge clk_i or posedge reset_i)
            begin
                if (reset_i)
                begin
                    ph_reg <= PH_SAME;
                    sl_reg <= '0;
                end
                else if (ce_i)
                begin
                    ph_reg <= ph_next;
                    sl_reg <= sl_next;
                end
            end

            assign boost_phase_o[ch] = ph_reg;
            assign slew_cfg_o[ch]    = sl_reg;
        end
    endgenerate

    assign alert_o       = alert_reg;
    assign soft_reset_o  = srst_reg;
    assign user_toggle_o = toggle_reg;
    assign boost_cfg_o   = boost_reg;
    assign boost_div_o   = div_reg;

    soft_reset_a: assert property (@(posedge clk_i) disable iff (reset_i)
        ce_i && soft_wr && code == CODE_RESET |=> soft_reset_o && boost_cfg_o.rate == RATE_DEF)
        else $error("reset key did not reset");
    other_code_a: assert property (@(posedge clk_i) disable iff (reset_i)
        ce_i && soft_wr && code != CODE_RESET |=> !soft_reset_o && $stable(boost_cfg_o))
        else $error("non-key code acted");
    toggle_copy_a: assert property (@(posedge clk_i) disable iff (reset_i)
        ce_i && soft_wr && code != CODE_RESET |=> user_toggle_o == $past(frame.word[TOGGLE_BIT]))
        else $error("toggle not mirrored");
    wdog_off_a: assert property (@(posedge clk_i) disable iff (reset_i)
        ce_i && !watchdog_enable_i |=> !alert_o && wd_cnt_reg == '0)
        else $error("alert while watchdog off");
    wdog_alert_a: assert property (@(posedge clk_i) disable iff (reset_i)
        ce_i && watchdog_enable_i && !soft_wr && wd_cnt_reg == WD_LAST - 1'b1 |=> alert_o)
        else $error("missed timeout");
    wdog_service_a: assert property (@(posedge clk_i) disable iff (reset_i)
        ce_i && service |=> wd_cnt_reg == '0 && !alert_o)
        else $error("service did not restart count");
    boost_write_a: assert property (@(posedge clk_i) disable iff (reset_i)
        ce_i && boost_wr |=> boost_cfg_o == $past(frame.word[6:0]))
        else $error("boost fields not stored");
    boost_rate_a: assert property (@(posedge clk_i) disable iff (reset_i)
        boost_cfg_o.rate == 2'h2 |-> boost_div_o == DIV2)
        else $error("wrong divider");
    phase_quad_a: assert property (@(posedge clk_i) disable iff (reset_i)
        boost_cfg_o.phase == 2'h3 |-> boost_phase_o[1] == 2'h1 && boost_phase_o[3] == 2'h3)
        else $error("quadrature phases wrong");
    read_only_a: assert property (@(posedge clk_i) disable iff (reset_i)
        ce_i && rd |=> $stable(boost_cfg_o) && $stable(slew_cfg_o) && load_reg)
        else $error("readback changed state");
    slew_chan_a: assert property (@(posedge clk_i) disable iff (reset_i)
        ce_i && slew_wr |=> slew_cfg_o[$past(slew_ch)].enable == $past(frame.word[SREN_BIT]))
        else $error("slew enable not stored");
endmodule : swbst_ctrl

`default_nettype wire

// ---- rtl/swbst_serial_rx.sv ----
// swbst_pkg: shared constants and carriers; swbst_serial_rx: serial frame receiver.
// assumes sclk, frame select and data arrive asynchronously from the host and
// are sampled by clk_i, which runs far faster than the serial clock.
`default_nettype none

package swbst_pkg;
    localparam int          FRAME_BITS   = 24;          // bits per serial frame
    localparam int          CNT_W        = 5;           // frame bit counter width
    localparam int          RW_BIT       = 23;          // read/write flag position
    localparam int          RD_LO        = 16;          // read address field low bit
    localparam int          CH_LO        = 16;          // channel field low bit
    localparam int          SEL_LO       = 13;          // register select low bit
    localparam int          TOGGLE_BIT   = 12;          // user toggle in soft register
    localparam int          SREN_BIT     = 12;          // slew enable in slew register
    localparam int          SRCLK_LO     = 3;           // slew clock field low bit
    localparam int          SRSTEP_LO    = 0;           // slew step field low bit
    localparam int          COMP_BIT     = 6;           // compensation select bit
    localparam int          PHASE_LO     = 4;           // phase field low bit
    localparam int          RATE_LO      = 2;           // switching rate field low bit
    localparam int          LIMIT_LO     = 0;           // voltage limit field low bit
    localparam int          STAT_TOG_BIT = 11;          // toggle mirror in status word
    localparam int          NUM_CH       = 4;           // converter channels
    localparam logic [2:0]  SEL_SOFT     = 3'h4;        // soft reset and keepalive
    localparam logic [2:0]  SEL_BOOST    = 3'h3;        // boost converter control
    localparam logic [2:0]  SEL_SLEW     = 3'h0;        // slew rate control
    localparam logic [11:0] CODE_RESET   = 12'h555;     // software reset key
    localparam logic [11:0] CODE_SERVICE = 12'h195;     // watchdog service key
    localparam logic [4:0]  RD_STATUS    = 5'h18;       // read status word
    localparam logic [4:0]  RD_BOOST     = 5'h1A;       // read boost control
    localparam logic [2:0]  RD_SLEW_GRP  = 3'h5;        // read slew, low 2 bits = channel
    localparam logic [1:0]  PHASE_DEF    = 2'h0;        // all channels same edge
    localparam logic [1:0]  RATE_DEF     = 2'h1;        // 410 kHz
    localparam logic [1:0]  LIMIT_DEF    = 2'h0;        // 23 V
    localparam logic        COMP_DEF     = 1'b0;        // internal resistor
    localparam logic [1:0]  PH_SAME      = 2'h0;        // quarter-period offset 0
    localparam logic [1:0]  PH_OPP       = 2'h2;        // opposite edge
    localparam int          OSC_HZ       = 13_000_000;  // internal oscillator
    localparam int          RATE0_HZ     = 250_000;
    localparam int          RATE1_HZ     = 410_000;
    localparam int          RATE2_HZ     = 650_000;
    localparam logic [5:0]  DIV0         = 6'(OSC_HZ / RATE0_HZ);
    localparam logic [5:0]  DIV1         = 6'(OSC_HZ / RATE1_HZ);
    localparam logic [5:0]  DIV2         = 6'(OSC_HZ / RATE2_HZ);
    localparam int          CLK_MHZ      = 100;         // clk_i rate
    localparam int          WDOG_TIMEOUT_US = 1000;     // watchdog timeout, microseconds

    typedef struct packed {
        logic       comp;
        logic [1:0] phase;
        logic [1:0] rate;
        logic [1:0] limit;
    } swbst_boost_s;

    typedef struct packed {
        logic       enable;
        logic [3:0] clock;
        logic [2:0] step;
    } swbst_slew_s;

    typedef struct packed {
        logic                  valid;
        logic [FRAME_BITS-1:0] word;
    } swbst_frame_s;
endpackage : swbst_pkg

module swbst_serial_rx
    import swbst_pkg::*;
(
    input  wire logic                  clk_i,
    input  wire logic                  reset_i,
    input  wire logic                  ce_i,
    input  wire logic                  sclk_i,
    input  wire logic                  sync_n_i,
    input  wire logic                  serial_in_line_i,
    input  wire logic                  sdo_load_i,
    input  wire logic [FRAME_BITS-1:0] sdo_word_i,
    output swbst_frame_s               frame_o,
    output logic                       sdo_o
);
    logic [2:0]            sclk_reg, sclk_next;   // sync pair plus edge history
    logic [2:0]            sync_reg, sync_next;
    logic [1:0]            din_reg,  din_next;
    logic [FRAME_BITS-1:0] shift_reg, shift_next; // incoming bits
    logic [CNT_W-1:0]      cnt_reg,   cnt_next;   // bits seen, saturating
    logic [FRAME_BITS-1:0] sdo_sr_reg, sdo_sr_next;
    logic                  sdo_reg,   sdo_next;
    swbst_frame_s          frame_reg, frame_next;
    logic                  fall, rise, active, start, stop;

    // synchronisers, edge finding, shifting and frame completion
    always_comb
    begin
        sclk_next   = {sclk_reg[1:0], sclk_i};
        sync_next   = {sync_reg[1:0], sync_n_i};
        din_next    = {din_reg[0], serial_in_line_i};
        fall        = sclk_reg[2] & ~sclk_reg[1];
        rise        = ~sclk_reg[2] & sclk_reg[1];
        active      = ~sync_reg[1];
        start       = sync_reg[2] & ~sync_reg[1];
        stop        = ~sync_reg[2] & sync_reg[1];
        shift_next  = shift_reg;
        cnt_next    = cnt_reg;
        sdo_sr_next = sdo_sr_reg;
        frame_next  = '{valid: 1'b0, word: shift_reg};
        if (start)
        begin
            cnt_next = '0;                         // new frame
        end
        else if (active && fall)
        begin
            // data is taken on the falling serial edge
            shift_next = {shift_reg[FRAME_BITS-2:0], din_reg[1]};
            if (cnt_reg != CNT_W'(FRAME_BITS + 1))
                cnt_next = cnt_reg + 1'b1;
        end
        if (stop && cnt_reg == CNT_W'(FRAME_BITS))
            frame_next.valid = 1'b1;               // frames of other lengths dropped
        if (sdo_load_i)
            sdo_sr_next = sdo_word_i;
        else if (active && rise)
            sdo_sr_next = {sdo_sr_reg[FRAME_BITS-2:0], 1'b0};
        sdo_next = sdo_sr_next[FRAME_BITS-1];
    end

    // state registers, frozen while ce_i is low
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            sclk_reg   <= '1;      // idle high, so no false edge after reset
            sync_reg   <= '1;
            din_reg    <= '0;
            shift_reg  <= '0;
            cnt_reg    <= '0;
            sdo_sr_reg <= '0;
            sdo_reg    <= 1'b0;
            frame_reg  <= '0;
        end
        else if (ce_i)
        begin
            sclk_reg   <= sclk_next;
            sync_reg   <= sync_next;
            din_reg    <= din_next;
            shift_reg  <= shift_next;
            cnt_reg    <= cnt_next;
            sdo_sr_reg <= sdo_sr_next;
            sdo_reg    <= sdo_next;
            frame_reg  <= frame_next;
        end
    end

    assign frame_o = frame_reg;
    assign sdo_o   = sdo_reg;

    // a short frame never reports
    short_frame_a: assert property (@(posedge clk_i) disable iff (reset_i)
        ce_i && stop && cnt_reg != CNT_W'(FRAME_BITS) |=> !frame_o.valid)
        else $error("frame of wrong length reported");
endmodule : swbst_serial_rx

`default_nettype wire

// ---- dv/swbst_host.sv ----
// swbst_host: behavioural host driving the 3-wire serial port of swbst_ctrl.
// assumes the device samples data on falling sclk and updates sdo after rising sclk.
`default_nettype none

module swbst_host (
    input  wire logic clk_i,    // bench clock, used to start frames and to time the gap after them
    input  wire logic sdo_i,    // readback data from the device
    output logic      sclk_o,   // serial clock, idles high between frames
    output logic      sync_n_o, // frame select, active low
    output logic      data_o    // serial data, msb first
);
    timeunit 1ns;
    timeprecision 100ps;

    localparam realtime HALF = 62.5; // half of the 125 ns link clock

    // idle levels at time zero
    initial
    begin
        sclk_o   = 1'b1;
        sync_n_o = 1'b1;
        data_o   = 1'b0;
    end

    // one whole 24-bit frame; rd collects sdo before each falling edge
    task automatic frame(input logic [23:0] w, output logic [23:0] rd);
        @(negedge clk_i);
        sync_n_o = 1'b0;
        #1; // keeps every sclk and data edge clear of a clk_i edge; sync_n falls on the negedge itself
        for (int i = 23; i >= 0; i--)
        begin
            data_o = w[i];
            #HALF;
            rd[i]  = sdo_i;
            sclk_o = 1'b0; // device shifts on this fall
            #HALF;
            sclk_o = 1'b1;
        end
        data_o   = ~w[0]; // released line shows no stale bit
        sync_n_o = 1'b1;
        repeat (8) @(negedge clk_i); // frame gap and decode time
    endtask : frame
endmodule : swbst_host

`default_nettype wire

// ---- dv/tb_swbst_ctrl.sv ----
// tb_swbst_ctrl: self-checking bench for the soft register and boost control decode.
// assumes swbst_pkg is compiled first and the watchdog period is shortened to 50.
`default_nettype none

module tb_swbst_ctrl
    import swbst_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    typedef struct packed {
        logic [23:0] w;   // frame sent
        logic [6:0]  cfg; // expected boost configuration
        logic [5:0]  div; // expected divider
        logic [7:0]  ph;  // expected per-channel phases
    } swbst_row_s;

    logic                   clk, reset, ce, wd_en, sclk, sync_n, sdi, sdo, alert, srst, tog;
    swbst_boost_s           cfg;
    logic [5:0]             div;
    logic [NUM_CH-1:0][1:0] ph;
    swbst_slew_s [NUM_CH-1:0] slew; // per-channel slew settings
    logic [23:0]            rd;
    int                     miscompares = 0, n_checks = 0, pulses = 0, p;
    // boost writes, all but the last with d12..d7 set, which must be ignored
    swbst_row_s rows [5] = '{
        '{24'h007F80, 7'h00, 6'h34, 8'h00},
        '{24'h007FD7, 7'h57, 6'h1F, 8'hA0},
        '{24'h007FA8, 7'h28, 6'h14, 8'h88},
        '{24'h007FBE, 7'h3E, 6'h1F, 8'hE4},
        '{24'h006009, 7'h09, 6'h14, 8'h00}};

    swbst_ctrl #(.WDOG_TIMEOUT_CYCLES(50)) i_swbst_ctrl (
        .clk_i(clk), .reset_i(reset), .ce_i(ce), .sclk_i(sclk), .sync_n_i(sync_n),
        .serial_in_line_i(sdi), .watchdog_enable_i(wd_en), .sdo_o(sdo), .alert_o(alert),
        .soft_reset_o(srst), .user_toggle_o(tog), .boost_cfg_o(cfg), .boost_div_o(div),
        .boost_phase_o(ph), .slew_cfg_o(slew));

    swbst_host i_swbst_host (.clk_i(clk), .sdo_i(sdo), .sclk_o(sclk), .sync_n_o(sync_n),
        .data_o(sdi));

    // 100 MHz clock
    initial clk = 1'b0;
    always #5 clk = ~clk;

    // count soft reset pulses
    always @(posedge clk)
        if (srst === 1'b1)
            pulses++;

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic results;
        $display("checks %0d, mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : results

    // watchdog: the whole run needs well under 200 us
    initial
    begin
        #200us;
        miscompares++;
        results();
    end

    initial
    begin
        reset = 1'b1;
        ce    = 1'b1;
        wd_en = 1'b0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        reset = 1'b0;
        chk(cfg, 24'h04);
        chk(div, 24'h1F);
        chk({alert, tog, ph}, 24'h0);
        $display("test reset done");
        foreach (rows[k])
        begin
            i_swbst_host.frame(rows[k].w, rd);
            chk(cfg, rows[k].cfg);
            chk(div, rows[k].div);
            chk(ph, rows[k].ph);
        end
        $display("test boost rows done");
        // read flag frame carrying boost bits must not write
        i_swbst_host.frame(24'hDA607F, rd);
        i_swbst_host.frame(24'hDA0000, rd);
        chk(cfg, 24'h09);
        chk(rd[6:0], 24'h09);
        $display("test readback done");
        // slew write to channel C only, then read it back
        i_swbst_host.frame(24'h021055, rd);
        chk(slew[2], 24'hD5);
        chk({slew[3], slew[1], slew[0]}, 24'h0);
        i_swbst_host.frame(24'h960000, rd);
        i_swbst_host.frame(24'h960000, rd);
        chk(rd[15:0], 24'h1055);
        $display("test slew done");
        // toggle bit set, read back, cleared; other code only toggles
        i_swbst_host.frame(24'h009000, rd);
        chk(tog, 24'h1);
        i_swbst_host.frame(24'hD80000, rd);
        i_swbst_host.frame(24'hD80000, rd);
        chk(rd[11], 24'h1);
        i_swbst_host.frame(24'h008000, rd);
        chk(tog, 24'h0);
        p = pulses;
        i_swbst_host.frame(24'h009AAA, rd);
        chk({tog, cfg}, 24'h89);
        chk(pulses - p, 24'h0);
        $display("test toggle done");
        // reset key restores defaults
        i_swbst_host.frame(24'h009555, rd);
        chk(pulses - p, 24'h1);
        chk({tog, cfg, div}, 24'h011F);
        chk(slew[2], 24'h0);
        $display("test soft reset done");
        // watchdog timeout, service, disable
        // clock enable low: the watchdog count must stay frozen
        ce    = 1'b0;
        wd_en = 1'b1;
        repeat (60) @(negedge clk);
        chk(alert, 24'h0);
        ce    = 1'b1;
        repeat (40) @(negedge clk);
        chk(alert, 24'h0);
        repeat (20) @(negedge clk);
        chk(alert, 24'h1);
        i_swbst_host.frame(24'h008195, rd);
        chk(alert, 24'h0);
        chk(pulses - p, 24'h1);
        wd_en = 1'b0;
        repeat (100) @(negedge clk);
        chk(alert, 24'h0);
        $display("test watchdog done");
        results();
    end
endmodule : tb_swbst_ctrl

`default_nettype wire
